/* btre_engine.sv */
// Replay engine: AHB-Lite register slave, code-word interpreter, timer, output buffer
// What this block does
// - Code bit 15 picks bus A or B
// - Bit 14: send following words, count low six
// - Bit 13: two words give release time, low first
// - Going active clears counter; steps every 500 ns
// - Hold send-words until counter equals release time
// - Bit 12 ends replay, clears active flag
// - Bit 8 inverts each word's parity bit
// - Bit 7 picks command or data sync
// - Bit 6: two words, low six bits count
// - Bit-length mode sends only second word's values
// - Go bit write sets the active flag
// - Counter wraps through full 32-bit range
//
// Implementation choices: the register offsets and the AHB-Lite register port.
module btre_engine #(
  parameter int ADDR_W = 10
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [31:0]      tx_word,
  output logic [5:0]       tx_bits,
  output logic             tx_bus_b,
  output logic             tx_sync_data,
  output logic             tx_parity
);
  initial
  begin
    if (ADDR_W < 2 || ADDR_W > 16) $error("ADDR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic                   rdy;
    logic [31:0]            rdata;
    logic                   a_wr;
    logic [7:0]             a_off;
    logic [ADDR_W-1:0]      buf_addr;
    logic                   active;
    btre_pkg::btre_state_type st;
    logic [ADDR_W-1:0]      rd_ptr;
    logic                   wait_pend;
    logic [31:0]            rel;
    logic [31:0]            cnt;
    logic [3:0]             pre;
    logic [15:0]            code;
    logic [5:0]             remaining;
    logic                   ov;
    btre_pkg::btre_ent_type od;
    logic                   sv;
    btre_pkg::btre_ent_type sd;
  } btre_regs_type;
  btre_regs_type          s;
  btre_regs_type          n;
  logic [15:0]            mem [2**ADDR_W];
  logic [15:0]            mem_q;
  logic                   acc;
  logic                   go_wr;
  logic                   push;
  logic                   pop;
  btre_pkg::btre_ent_type pd;
  logic                   ctrl_wr; // Go or abort may legally cut any sequence short
  // Odd parity over the first n bits, MSB first
  function automatic logic odd_par(input logic [31:0] w, input logic [5:0] nb);
    logic p;
    p = 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      if (i < int'(nb)) p = p ^ w[31-i];
    end
    return p;
  endfunction : odd_par
  // Register read decode; unmapped offsets read zero
  function automatic logic [31:0] rd_mux(input logic [7:0] off, input btre_regs_type r);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (off)
      btre_pkg::STATUS_OFF:
      begin
        v[btre_pkg::STAT_ACTIVE_BIT]  = r.active;
        v[btre_pkg::STAT_WAIT_BIT]    = r.wait_pend;
        v[btre_pkg::STAT_TXVALID_BIT] = r.ov;
      end
      btre_pkg::BUF_ADDR_OFF: v[ADDR_W-1:0] = r.buf_addr;
      btre_pkg::TIMER_OFF:    v = r.cnt;
      default:                v = 32'h0000_0000;
    endcase
    return v;
  endfunction : rd_mux
  assign mem_q = mem[s.rd_ptr];
  assign acc   = hsel & htrans[1] & hready;
  assign go_wr = s.a_wr && s.a_off == btre_pkg::CTRL_OFF && hwdata[btre_pkg::CTRL_GO_BIT];
  assign ctrl_wr = s.a_wr && s.a_off == btre_pkg::CTRL_OFF;
  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    n    = s;
    push = 1'b0;
    pd   = '0;
    pop  = s.ov & tx_ready;
    // Address phase; zero wait states so read data is captured now
    n.rdy  = 1'b1;
    n.a_wr = acc & hwrite;
    n.a_off = haddr[7:0];
    if (acc && !hwrite) n.rdata = rd_mux(haddr[7:0], s);
    // Half-microsecond timer runs only while active, wraps naturally
    if (s.active)
    begin
      if (s.pre == btre_pkg::TICK_LAST)
      begin
        n.pre = 4'h0;
        n.cnt = s.cnt + 32'h0000_0001;
      end
      else
        n.pre = s.pre + 4'h1;
    end
    // Interpreter; nothing moves while inactive
    if (s.active)
    begin
      unique case (s.st)
        btre_pkg::S_CODE:
        begin
          if (mem_q[btre_pkg::CODE_END_BIT])
          begin
            n.active = 1'b0;
            n.st     = btre_pkg::S_IDLE;
          end
          else if (mem_q[btre_pkg::CODE_TIME_BIT])
          begin
            n.rd_ptr = s.rd_ptr + 1'b1;
            n.st     = btre_pkg::S_TLO;
          end
          else if (mem_q[btre_pkg::CODE_XMIT_BIT])
          begin
            // A pending release time holds the words back
            if (!s.wait_pend || s.cnt == s.rel)
            begin
              n.code      = mem_q;
              n.remaining = mem_q[btre_pkg::CODE_CNT_MSB:0];
              n.wait_pend = 1'b0;
              n.rd_ptr    = s.rd_ptr + 1'b1;
              n.st = mem_q[btre_pkg::CODE_BLEN_BIT] ? btre_pkg::S_BL1 : btre_pkg::S_WORD;
            end
          end
          else
            n.rd_ptr = s.rd_ptr + 1'b1; // Unknown code skipped
        end
        btre_pkg::S_TLO:
        begin
          n.rel[15:0] = mem_q;
          n.rd_ptr    = s.rd_ptr + 1'b1;
          n.st        = btre_pkg::S_THI;
        end
        btre_pkg::S_THI:
        begin
          n.rel[31:16] = mem_q;
          n.wait_pend  = 1'b1;
          n.rd_ptr     = s.rd_ptr + 1'b1;
          n.st         = btre_pkg::S_CODE;
        end
        btre_pkg::S_WORD:
        begin
          // A zero count (illegal) sends nothing rather than 64 words
          if (s.remaining == 6'h00)
            n.st = btre_pkg::S_CODE;
          else if (!s.sv)
          begin
            push = 1'b1;
            pd.word = {mem_q, 16'h0000};
            pd.bits = btre_pkg::WORD_BITS;
            n.rd_ptr    = s.rd_ptr + 1'b1;
            n.remaining = s.remaining - 6'h01;
            if (s.remaining == 6'h01) n.st = btre_pkg::S_CODE;
          end
        end
        btre_pkg::S_BL1:
        begin
          // First word's values are never sent, only its slot
          n.rd_ptr = s.rd_ptr + 1'b1;
          n.st     = btre_pkg::S_BL2;
        end
        btre_pkg::S_BL2:
        begin
          if (!s.sv)
          begin
            push = 1'b1;
            pd.word = {mem_q, 16'h0000};
            pd.bits = (s.code[5:0] > btre_pkg::MAX_BITS) ? btre_pkg::MAX_BITS
                                                         : s.code[5:0];
            n.rd_ptr = s.rd_ptr + 1'b1;
            n.st     = btre_pkg::S_CODE;
          end
        end
        default: n.st = btre_pkg::S_IDLE;
      endcase
    end
    pd.bus_b     = s.code[btre_pkg::CODE_BUS_BIT];
    pd.sync_data = s.code[btre_pkg::CODE_SYNC_BIT];
    pd.par = odd_par(pd.word, pd.bits) ^ s.code[btre_pkg::CODE_PINV_BIT];
    // Register writes in data phase; go wins over the interpreter
    if (s.a_wr)
    begin
      unique case (s.a_off)
        btre_pkg::CTRL_OFF:
        begin
          if (hwdata[btre_pkg::CTRL_GO_BIT])
          begin
            n.active    = 1'b1;
            n.cnt       = 32'h0000_0000;
            n.pre       = 4'h0;
            n.rd_ptr    = '0;
            n.wait_pend = 1'b0;
            n.st        = btre_pkg::S_CODE;
          end
          else if (hwdata[btre_pkg::CTRL_ABORT_BIT])
          begin
            n.active = 1'b0;
            n.st     = btre_pkg::S_IDLE;
          end
        end
        btre_pkg::BUF_ADDR_OFF: n.buf_addr = hwdata[ADDR_W-1:0];
        btre_pkg::BUF_DATA_OFF: n.buf_addr = s.buf_addr + 1'b1;
        default: ;
      endcase
    end
    // Two-entry buffer: output stage plus skid, so a stall loses nothing
    if (pop)
    begin
      if (s.sv)
      begin
        n.od = s.sd;
        n.sv = 1'b0;
      end
      else
        n.ov = 1'b0;
    end
    if (push)
    begin
      if (!n.ov)
      begin
        n.ov = 1'b1;
        n.od = pd;
      end
      else
      begin
        n.sv = 1'b1;
        n.sd = pd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s     <= '0;
      s.rdy <= 1'b1;
    end
    else
      s <= n;
  end
  // Buffer memory written by software, no reset needed
  always_ff @(posedge hclk)
  begin
    if (s.a_wr && s.a_off == btre_pkg::BUF_DATA_OFF) mem[s.buf_addr] <= hwdata[15:0];
  end
  assign hreadyout    = s.rdy;
  assign hresp        = 1'b0; // Always OKAY
  assign hrdata       = s.rdata;
  assign tx_valid     = s.ov;
  assign tx_word      = s.od.word;
  assign tx_bits      = s.od.bits;
  assign tx_bus_b     = s.od.bus_b;
  assign tx_sync_data = s.od.sync_data;
  assign tx_parity    = s.od.par;
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_go_active: assert property (go_wr |=> s.active && s.cnt == 32'h0000_0000)
    else $error("go write did not start replay");
  a_tick_step: assert property (
    s.active && s.pre == btre_pkg::TICK_LAST && !go_wr |=> s.cnt == $past(s.cnt) + 32'h1)
    else $error("timer did not step");
  a_cnt_halt: assert property (!s.active && !go_wr |=> $stable(s.cnt))
    else $error("timer ran while inactive");
  a_end_stop: assert property (
    s.active && s.st == btre_pkg::S_CODE && mem_q[btre_pkg::CODE_END_BIT] && !go_wr
    |=> !s.active)
    else $error("end code did not stop replay");
  a_hold_time: assert property (
    s.active && s.st == btre_pkg::S_CODE && s.wait_pend && s.cnt != s.rel
    && mem_q[14:12] == 3'b100 && !ctrl_wr |=> s.st == btre_pkg::S_CODE && $stable(s.rd_ptr))
    else $error("words released early");
  a_time_halves: assert property (
    s.active && s.st == btre_pkg::S_THI && !go_wr
    |=> s.rel == {$past(mem_q), $past(s.rel[15:0])} && s.wait_pend)
    else $error("release time assembled wrongly");
  a_par_inv: assert property (
    push && s.code[btre_pkg::CODE_PINV_BIT] && pd.bits == btre_pkg::WORD_BITS
    |-> pd.par == ^pd.word[31:16])
    else $error("parity not inverted");
  a_blen_pair: assert property (
    s.active && s.st == btre_pkg::S_BL1 && !ctrl_wr |=> s.st == btre_pkg::S_BL2)
    else $error("bit-length code did not take two words");
  a_word_seq: assert property (
    s.st == btre_pkg::S_WORD && s.remaining == 6'h01 && push && !ctrl_wr
    |=> s.st == btre_pkg::S_CODE && s.rd_ptr == $past(s.rd_ptr) + 1'b1)
    else $error("word sequence broken");
  a_no_loss: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
    else $error("stalled word changed");
  c_end_hit: cover property (s.active ##1 !s.active);
  c_released: cover property (s.wait_pend ##1 !s.wait_pend && s.st != btre_pkg::S_IDLE);
  c_blen_push: cover property (push && s.st == btre_pkg::S_BL2);
  c_skid_full: cover property (s.sv && !tx_ready);
endmodule : btre_engine

/* btre_pkg.sv */
// Package: register map, code-word fields, timing and types of the replay engine
package btre_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] STATUS_OFF   = 8'h04;
  localparam logic [7:0] BUF_ADDR_OFF = 8'h08;
  localparam logic [7:0] BUF_DATA_OFF = 8'h0C;
  localparam logic [7:0] TIMER_OFF    = 8'h10;
  // Control and status bit positions
  localparam int CTRL_GO_BIT      = 0;
  localparam int CTRL_ABORT_BIT   = 1;
  localparam int STAT_ACTIVE_BIT  = 2;
  localparam int STAT_WAIT_BIT    = 3;
  localparam int STAT_TXVALID_BIT = 4;
  // Code-word field positions
  localparam int CODE_BUS_BIT   = 15;
  localparam int CODE_XMIT_BIT  = 14;
  localparam int CODE_TIME_BIT  = 13;
  localparam int CODE_END_BIT   = 12;
  localparam int CODE_PINV_BIT  = 8;
  localparam int CODE_SYNC_BIT  = 7;
  localparam int CODE_BLEN_BIT  = 6;
  localparam int CODE_CNT_MSB   = 5;
  localparam logic [5:0] MAX_BITS  = 6'h20;
  localparam logic [5:0] WORD_BITS = 6'h10;
  // Timing: one counter step per half microsecond
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS       = 500;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1);
  // Engine states
  typedef enum logic [2:0] {
    S_IDLE, S_CODE, S_TLO, S_THI, S_WORD, S_BL1, S_BL2
  } btre_state_type;
  // One bus word handed to the encoder
  typedef struct packed {
    logic        bus_b;
    logic        sync_data;
    logic        par;
    logic [5:0]  bits;
    logic [31:0] word;
  } btre_ent_type;
endpackage : btre_pkg

/* btre_sink.sv */
// Partner model: word encoder that takes replayed bus words
module btre_sink (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hold,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [31:0] tx_word,
  input  wire logic [5:0]  tx_bits,
  input  wire logic        tx_bus_b,
  input  wire logic        tx_sync_data,
  input  wire logic        tx_parity
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  ph_ff;
  logic [40:0] got_q[$];
  int          stamp_q[$];
  int          cyc;
  // Busy every other cycle, so the engine must hold its word
  assign tx_ready = !hold && ph_ff[0];
  //////////////////////////////////////////////////////////////////
  // Log every word taken, with the cycle it was taken in
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_ff <= 4'h0;
      cyc <= 0;
    end
    else
    begin
      ph_ff <= ph_ff + 4'h1;
      cyc <= cyc + 1;
      if (tx_valid && tx_ready)
      begin
        got_q.push_back({tx_bus_b, tx_sync_data, tx_parity, tx_bits, tx_word});
        stamp_q.push_back(cyc);
      end
    end
  end
endmodule : btre_sink

/* testbench.sv */
// Testbench: register access over AHB-Lite and replay of one buffer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic        hreadyout, hresp, tx_valid, tx_ready, tx_bus_b, tx_sync_data, tx_parity;
  logic [31:0] hrdata, tx_word, r, t1;
  logic [5:0]  tx_bits;
  logic        hold = 0;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          g;
  logic [15:0] img[11] = '{16'h2000, 16'h0008, 16'h0000, 16'h4001, 16'h0422,
    16'hC181, 16'h1111, 16'h4068, 16'hAAAA, 16'h5555, 16'h1000};
  logic [40:0] ex[3] = '{{3'b000, 6'h10, 32'h0422_0000},
    {3'b110, 6'h10, 32'h1111_0000}, {3'b001, 6'h20, 32'h5555_0000}};
  always #25 hclk = ~hclk;
  btre_engine #(.ADDR_W(4)) i_btre_engine (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word), .tx_bits(tx_bits),
    .tx_bus_b(tx_bus_b), .tx_sync_data(tx_sync_data), .tx_parity(tx_parity));
  btre_sink i_btre_sink (.hclk(hclk), .hresetn(hresetn), .hold(hold), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_word(tx_word), .tx_bits(tx_bits), .tx_bus_b(tx_bus_b),
    .tx_sync_data(tx_sync_data), .tx_parity(tx_parity));
  //////////////////////////////////////////////////////////////////
  // Counts and verdict
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One single transfer; waits for hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0000_00, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  // Hang guard: a full run needs well under this many cycles
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////
  // Main sequence: load, replay twice, with and without stalls
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, btre_pkg::STATUS_OFF, 0);
    chk(r, 0);
    bus(0, 8'h20, 0);
    chk(r, 0);
    bus(1, btre_pkg::BUF_ADDR_OFF, 0);
    foreach (img[i]) bus(1, btre_pkg::BUF_DATA_OFF, {16'h0000, img[i]});
    for (int run = 0; run < 2; run++)
    begin
      hold <= (run == 1);
      bus(1, btre_pkg::CTRL_OFF, 1);
      g = i_btre_sink.cyc;
      bus(0, btre_pkg::TIMER_OFF, 0);
      chk(r < 2, 1);
      bus(0, btre_pkg::STATUS_OFF, 0);
      chk(r[2], 1);
      repeat (150) @(posedge hclk);
      hold <= 1'b0;
      for (int k = 0; k < 200 && i_btre_sink.got_q.size() < 3 * run + 3; k++)
        @(posedge hclk);
      if (run == 0)
        chk(i_btre_sink.stamp_q[0] - g >= 80 && i_btre_sink.stamp_q[0] - g < 96, 1);
      for (int k = 0; k < 3; k++)
        chk(i_btre_sink.got_q[3 * run + k], ex[k]);
      bus(0, btre_pkg::STATUS_OFF, 0);
      chk(r[2], 0);
      bus(0, btre_pkg::TIMER_OFF, 0);
      t1 = r;
      // Unstalled run ends before the tick after release time 8; stalled run ends later
      chk(run == 0 ? t1 == 32'h0000_0008 : t1 > 32'h0000_0008, 1);
      repeat (30) @(posedge hclk);
      bus(0, btre_pkg::TIMER_OFF, 0);
      chk(r, t1);
    end
    // Abort while the first release time is still being read: no word, timer frozen
    bus(1, btre_pkg::CTRL_OFF, 1);
    bus(1, btre_pkg::CTRL_OFF, 2);
    bus(0, btre_pkg::STATUS_OFF, 0);
    chk(r[2], 0);
    repeat (20) @(posedge hclk);
    bus(0, btre_pkg::TIMER_OFF, 0);
    chk(r, 0);
    chk(i_btre_sink.got_q.size(), 6);
    give_verdict();
  end
endmodule : testbench
